// [core/rsd_map.svh]
/*
 * Offsets, field positions, reset values and timing counts of the
 * repeater strap decoder. Assumes a 250 MHz system clock.
 */
`ifndef RSD_MAP_SVH
`define RSD_MAP_SVH

// Setting register offsets
`define RSD_REG_CTRL      8'h06
`define RSD_REG_SDTH      8'h08
`define RSD_REG_EQ_A      8'h0f
`define RSD_REG_EQ_B      8'h16
`define RSD_REG_DRV_A     8'h23
`define RSD_REG_DRV_B     8'h2b

// Field positions
`define RSD_CTRL_REG_EN   3
`define RSD_DRV_AMP_LSB   2
`define RSD_DRV_DEM_LSB   5

// Bits that an EEPROM load may write
`define RSD_LOAD_MASK_EQ  8'hff
`define RSD_LOAD_MASK_DRV 8'hfc

// Reset values
`define RSD_RST_CTRL      8'h00
`define RSD_RST_SDTH      4'h0
`define RSD_RST_EQ        8'h00
`define RSD_RST_DRV       8'h00

// Slave address base, address byte 0xb0 with all straps low
`define RSD_SLAVE_BASE    7'h58
// Amplitude code for the 700 mVpp setting
`define RSD_AMP_700MV     3'h0

// Strap settle time after reset release
`define RSD_CLK_PERIOD_NS 4
`define RSD_SETTLE_NS     100
`define RSD_SETTLE_CYC    \
    ((`RSD_SETTLE_NS + `RSD_CLK_PERIOD_NS - 1) / `RSD_CLK_PERIOD_NS)

`endif

// [core/rsd_pkg.sv]
/*
 * Types of the repeater strap decoder.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package rsd_pkg;

    typedef enum logic [1:0] {
        RSD_LVL_0 = 2'h0,
        RSD_LVL_R = 2'h1,
        RSD_LVL_F = 2'h2,
        RSD_LVL_1 = 2'h3
    } rsd_level_t;

    typedef struct packed {
        rsd_level_t idle;
        rsd_level_t cfg;
        rsd_level_t eqah;
        rsd_level_t eqal;
        rsd_level_t eqbh;
        rsd_level_t eqbl;
        rsd_level_t amp;
        rsd_level_t dema;
        rsd_level_t demb;
        logic [3:0] addr;
    } rsd_straps_t;

    typedef enum logic [5:0] {
        RSD_ST_SETTLE = 6'h01,
        RSD_ST_SAMPLE = 6'h02,
        RSD_ST_PIN    = 6'h04,
        RSD_ST_SLAVE  = 6'h08,
        RSD_ST_LOAD   = 6'h10,
        RSD_ST_STALL  = 6'h20
    } rsd_state_t;

endpackage

`default_nettype wire

// [core/rsd_strap_if.sv]
/*
 * Carries the resolved strap levels from the resolver to the decoder.
 * Assumes both ends run on the same clock.
 */
`default_nettype none

interface rsd_strap_if;
    rsd_pkg::rsd_straps_t straps;
    modport res (output straps);
    modport dec (input  straps);
endinterface

`default_nettype wire

// [core/rsd_strap_res.sv]
/*
 * Synchronises the strap comparator outputs and resolves each strap
 * into one of four levels. Assumes a 3-bit thermometer per strap.
 */
`default_nettype none

module rsd_strap_res (
    input  wire logic             mclk_in,  // System clock
    input  wire logic             rst_b_in, // Async reset, low
    input  wire logic [8:0][2:0]  therm_in, // Strap comparators
    input  wire logic [3:0]       addr_in,  // Address straps
    rsd_strap_if.res              lv        // Resolved levels
);

    logic [30:0]          s1_q, s1_d;
    logic [30:0]          s2_q, s2_d;
    rsd_pkg::rsd_straps_t lv_q, lv_d;

    // Ones are counted, so a comparator bubble still lands on a level
    function automatic rsd_pkg::rsd_level_t resolve(input logic [2:0] t);
        logic [1:0] n;
        n = {1'b0, t[0]} + {1'b0, t[1]} + {1'b0, t[2]};
        return rsd_pkg::rsd_level_t'(n);
    endfunction

    always_comb begin
        s1_d = {therm_in, addr_in};
        s2_d = s1_q;
        lv_d.idle = resolve(s2_q[6:4]);
        lv_d.cfg  = resolve(s2_q[9:7]);
        lv_d.eqah = resolve(s2_q[12:10]);
        lv_d.eqal = resolve(s2_q[15:13]);
        lv_d.eqbh = resolve(s2_q[18:16]);
        lv_d.eqbl = resolve(s2_q[21:19]);
        lv_d.amp  = resolve(s2_q[24:22]);
        lv_d.dema = resolve(s2_q[27:25]);
        lv_d.demb = resolve(s2_q[30:28]);
        lv_d.addr = s2_q[3:0];
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s1_q <= '0;
            s2_q <= '0;
            lv_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            lv_q <= lv_d;
        end
    end

    assign lv.straps = lv_q;

    lvl_map_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        s2_q[6:4] == 3'h7 |=> lv_q.idle == rsd_pkg::RSD_LVL_1)
        else $error("Full thermometer did not resolve to level 1");

endmodule

`default_nettype wire

// [core/rsd_top.sv]
/*
 * Configuration logic of a one-lane repeater: strap decode, mode
 * select, EEPROM load control and the setting registers. Assumes an
 * SMBus slave engine and an EEPROM master engine on the same clock.
 */
// Notes on behaviour
// - Threshold strap 0,R,F,1 gives codes 10,01,00,11.
// - Floating mode strap makes the device master, loading from EEPROM.
// - EEPROM load writes only a subset of setting bits.
// - Good load returns to slave mode and releases the bus.
// - Failed load stalls forever with no bus access.
// - Each comparator strap resolves to exactly one of four levels; address straps pass as bits.
// - Pin mode reaches 16 equalizer codes, registers reach all 256.
// - Equalizer pairs with high strap 0 or R decode per table.
// - Equalizer pairs with high strap F or 1 decode; sides independent.
// - Amplitude and de-emphasis straps select a fixed code pair.
// - Amplitude strap 0,F,R: de-emphasis 0,F,R,1 gives 000,010,011,101.
// - Amplitude strap 0,F,R gives amplitude 000,011,101.
// - Amplitude strap 1: de-emphasis strap selects fixed code pairs.
// - Side A amplitude held at 700 mVpp in pin mode.
// - Amplitude strap 1 in pin mode enables back-channel training.
// - SMBus modes with amplitude strap 1 force address straps to 0.
// - Mode strap 0 pin, 1 slave, floating master with load.
// - Address straps are added to the base address; zero gives byte 0xb0.
`include "rsd_map.svh"
`default_nettype none

module rsd_top (
    input  wire logic       mclk_in,                     // Clock
    input  wire logic       rst_b_in,                    // Reset, low
    input  wire logic [2:0] idle_detect_threshold_strap_in, // Therm
    input  wire logic [2:0] config_mode_strap_in,        // Therm
    input  wire logic [2:0] side_a_eq_strap_hi_in,       // Therm
    input  wire logic [2:0] side_a_eq_strap_lo_in,       // Therm
    input  wire logic [2:0] side_b_eq_strap_hi_in,       // Therm
    input  wire logic [2:0] side_b_eq_strap_lo_in,       // Therm
    input  wire logic [2:0] amplitude_select_strap_in,   // Therm
    input  wire logic [2:0] deemph_strap_a_in,           // Therm
    input  wire logic [2:0] deemph_strap_b_in,           // Therm
    input  wire logic [3:0] slave_addr_straps_in,        // Address
    input  wire logic       slv_wr_in,                   // Slave write
    input  wire logic [7:0] slv_addr_in,                 // Write offset
    input  wire logic [7:0] slv_wdata_in,                // Write data
    input  wire logic [7:0] slv_rd_addr_in,              // Read offset
    output logic      [7:0] slv_rdata_out,               // Read data
    input  wire logic       load_wr_in,                  // Load write
    input  wire logic [7:0] load_addr_in,                // Load offset
    input  wire logic [7:0] load_data_in,                // Load data
    input  wire logic       load_done_in,                // Load good
    input  wire logic       load_fail_in,                // Load bad
    output logic            load_req_out,                // Run load
    output logic            bus_master_out,              // Own bus
    output logic            smbus_access_en_out,         // Slave on
    output logic            stalled_out,                 // Stalled
    output logic            pin_mode_out,                // Pin mode
    output logic      [6:0] slave_addr_out,              // Address
    output logic      [7:0] eq_a_out,                    // EQ side A
    output logic      [7:0] eq_b_out,                    // EQ side B
    output logic      [2:0] deemph_a_out,                // De-emph A
    output logic      [2:0] deemph_b_out,                // De-emph B
    output logic      [2:0] output_amplitude_a_out,      // Ampl A
    output logic      [2:0] output_amplitude_b_out,      // Ampl B
    output logic      [3:0] sd_thresh_out,               // Threshold
    output logic            kr_train_en_out              // Training
);

    rsd_strap_if strap_bus ();

    rsd_strap_res u_res (
        .mclk_in  (mclk_in),
        .rst_b_in (rst_b_in),
        .therm_in ({deemph_strap_b_in, deemph_strap_a_in,
                    amplitude_select_strap_in, side_b_eq_strap_lo_in,
                    side_b_eq_strap_hi_in, side_a_eq_strap_lo_in,
                    side_a_eq_strap_hi_in, config_mode_strap_in,
                    idle_detect_threshold_strap_in}),
        .addr_in  (slave_addr_straps_in),
        .lv       (strap_bus.res)
    );

    rsd_pkg::rsd_state_t  st_q, st_d;
    rsd_pkg::rsd_straps_t held_q, held_d;
    logic [7:0]           cnt_q, cnt_d;
    logic [6:0]           addr_q, addr_d;
    logic [7:0]           ctrl_q, ctrl_d;
    logic [3:0]           sdth_q, sdth_d;
    logic [7:0]           eq_a_q, eq_a_d, eq_b_q, eq_b_d;
    logic [7:0]           drv_a_q, drv_a_d, drv_b_q, drv_b_d;
    logic [7:0]           rdata_q, rdata_d;
    logic                 set_wr;

    function automatic logic [1:0] thr_code(input rsd_pkg::rsd_level_t l);
        case (l)
            rsd_pkg::RSD_LVL_0: thr_code = 2'h2;
            rsd_pkg::RSD_LVL_R: thr_code = 2'h1;
            rsd_pkg::RSD_LVL_1: thr_code = 2'h3;
            default:            thr_code = 2'h0;
        endcase
    endfunction

    // Only 16 of the 256 codes are reachable from straps
    function automatic logic [7:0] eq_code(input rsd_pkg::rsd_level_t hi,
                                           input rsd_pkg::rsd_level_t lo);
        case ({hi, lo})
            4'h0: eq_code = 8'h00;
            4'h1: eq_code = 8'h01;
            4'h2: eq_code = 8'h02;
            4'h3: eq_code = 8'h03;
            4'h4: eq_code = 8'h07;
            4'h5: eq_code = 8'h15;
            4'h6: eq_code = 8'h0b;
            4'h7: eq_code = 8'h0f;
            4'h8: eq_code = 8'h55;
            4'h9: eq_code = 8'h1f;
            4'ha: eq_code = 8'h2f;
            4'hb: eq_code = 8'h3f;
            4'hc: eq_code = 8'haa;
            4'hd: eq_code = 8'h7f;
            4'he: eq_code = 8'hbf;
            default: eq_code = 8'hff;
        endcase
    endfunction

    // Returns {de-emphasis, amplitude} as one fixed pair
    function automatic logic [5:0] drv_code(input rsd_pkg::rsd_level_t a,
                                            input rsd_pkg::rsd_level_t d);
        logic [2:0] dem;
        logic [2:0] amp;
        dem = 3'h0;
        amp = 3'h0;
        if (a == rsd_pkg::RSD_LVL_1) begin
            case (d)
                rsd_pkg::RSD_LVL_0: begin dem = 3'h0; amp = 3'h4; end
                rsd_pkg::RSD_LVL_F: begin dem = 3'h1; amp = 3'h4; end
                rsd_pkg::RSD_LVL_R: begin dem = 3'h1; amp = 3'h6; end
                default:            begin dem = 3'h2; amp = 3'h6; end
            endcase
        end else begin
            case (a)
                rsd_pkg::RSD_LVL_F: amp = 3'h3;
                rsd_pkg::RSD_LVL_R: amp = 3'h5;
                default:            amp = 3'h0;
            endcase
            case (d)
                rsd_pkg::RSD_LVL_F: dem = 3'h2;
                rsd_pkg::RSD_LVL_R: dem = 3'h3;
                rsd_pkg::RSD_LVL_1: dem = 3'h5;
                default:            dem = 3'h0;
            endcase
        end
        drv_code = {dem, amp};
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] val,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (val & mask);
    endfunction

    // Setting writes from the host need the enable bit
    assign set_wr = (st_q == rsd_pkg::RSD_ST_SLAVE) && slv_wr_in &&
                    ctrl_q[`RSD_CTRL_REG_EN];

    always_comb begin
        logic [5:0] pa;
        logic [5:0] pb;
        pa      = drv_code(held_q.amp, held_q.dema);
        pb      = drv_code(held_q.amp, held_q.demb);
        st_d    = st_q;
        held_d  = held_q;
        cnt_d   = cnt_q;
        addr_d  = addr_q;
        ctrl_d  = ctrl_q;
        sdth_d  = sdth_q;
        eq_a_d  = eq_a_q;
        eq_b_d  = eq_b_q;
        drv_a_d = drv_a_q;
        drv_b_d = drv_b_q;
        rdata_d = 8'h00;
        case (st_q)
            rsd_pkg::RSD_ST_SETTLE: begin
                cnt_d = cnt_q + 8'h01;
                if (cnt_q == 8'(`RSD_SETTLE_CYC - 1)) begin
                    st_d = rsd_pkg::RSD_ST_SAMPLE;
                end
            end
            rsd_pkg::RSD_ST_SAMPLE: begin
                held_d = strap_bus.straps;
                // Added, not ORed: the base has bit 3 set
                addr_d = `RSD_SLAVE_BASE + {3'h0,
                         strap_bus.straps.addr};
                if (strap_bus.straps.amp == rsd_pkg::RSD_LVL_1) begin
                    addr_d = `RSD_SLAVE_BASE;
                end
                case (strap_bus.straps.cfg)
                    rsd_pkg::RSD_LVL_1: st_d = rsd_pkg::RSD_ST_SLAVE;
                    rsd_pkg::RSD_LVL_F: st_d = rsd_pkg::RSD_ST_LOAD;
                    default:            st_d = rsd_pkg::RSD_ST_PIN;
                endcase
            end
            rsd_pkg::RSD_ST_PIN: begin
                sdth_d  = {2{thr_code(held_q.idle)}};
                eq_a_d  = eq_code(held_q.eqah, held_q.eqal);
                eq_b_d  = eq_code(held_q.eqbh, held_q.eqbl);
                drv_a_d = {pa[5:3], `RSD_AMP_700MV,
                           drv_a_q[1:0]};
                drv_b_d = {pb, drv_b_q[1:0]};
            end
            rsd_pkg::RSD_ST_LOAD: begin
                if (load_wr_in) begin
                    case (load_addr_in)
                        `RSD_REG_EQ_A:  eq_a_d  = merge(eq_a_q,
                            load_data_in, `RSD_LOAD_MASK_EQ);
                        `RSD_REG_EQ_B:  eq_b_d  = merge(eq_b_q,
                            load_data_in, `RSD_LOAD_MASK_EQ);
                        `RSD_REG_DRV_A: drv_a_d = merge(drv_a_q,
                            load_data_in, `RSD_LOAD_MASK_DRV);
                        `RSD_REG_DRV_B: drv_b_d = merge(drv_b_q,
                            load_data_in, `RSD_LOAD_MASK_DRV);
                        default: ;
                    endcase
                end
                // A failure outranks a done raised together
                if (load_fail_in) begin
                    st_d = rsd_pkg::RSD_ST_STALL;
                end else if (load_done_in) begin
                    st_d = rsd_pkg::RSD_ST_SLAVE;
                end
            end
            rsd_pkg::RSD_ST_SLAVE: begin
                if (slv_wr_in && slv_addr_in == `RSD_REG_CTRL) begin
                    ctrl_d = slv_wdata_in;
                end
                if (set_wr) begin
                    case (slv_addr_in)
                        `RSD_REG_SDTH:  sdth_d  = slv_wdata_in[3:0];
                        `RSD_REG_EQ_A:  eq_a_d  = slv_wdata_in;
                        `RSD_REG_EQ_B:  eq_b_d  = slv_wdata_in;
                        `RSD_REG_DRV_A: drv_a_d = slv_wdata_in;
                        `RSD_REG_DRV_B: drv_b_d = slv_wdata_in;
                        default: ;
                    endcase
                end
                case (slv_rd_addr_in)
                    `RSD_REG_CTRL:  rdata_d = ctrl_q;
                    `RSD_REG_SDTH:  rdata_d = {4'h0, sdth_q};
                    `RSD_REG_EQ_A:  rdata_d = eq_a_q;
                    `RSD_REG_EQ_B:  rdata_d = eq_b_q;
                    `RSD_REG_DRV_A: rdata_d = drv_a_q;
                    `RSD_REG_DRV_B: rdata_d = drv_b_q;
                    default:        rdata_d = 8'h00;
                endcase
            end
            rsd_pkg::RSD_ST_STALL: st_d = rsd_pkg::RSD_ST_STALL;
            default: st_d = rsd_pkg::RSD_ST_SETTLE;
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_q    <= rsd_pkg::RSD_ST_SETTLE;
            held_q  <= '0;
            cnt_q   <= 8'h00;
            addr_q  <= `RSD_SLAVE_BASE;
            ctrl_q  <= `RSD_RST_CTRL;
            sdth_q  <= `RSD_RST_SDTH;
            eq_a_q  <= `RSD_RST_EQ;
            eq_b_q  <= `RSD_RST_EQ;
            drv_a_q <= `RSD_RST_DRV;
            drv_b_q <= `RSD_RST_DRV;
            rdata_q <= 8'h00;
        end else begin
            st_q    <= st_d;
            held_q  <= held_d;
            cnt_q   <= cnt_d;
            addr_q  <= addr_d;
            ctrl_q  <= ctrl_d;
            sdth_q  <= sdth_d;
            eq_a_q  <= eq_a_d;
            eq_b_q  <= eq_b_d;
            drv_a_q <= drv_a_d;
            drv_b_q <= drv_b_d;
            rdata_q <= rdata_d;
        end
    end

    assign pin_mode_out        = (st_q == rsd_pkg::RSD_ST_PIN);
    assign load_req_out        = (st_q == rsd_pkg::RSD_ST_LOAD);
    assign bus_master_out      = (st_q == rsd_pkg::RSD_ST_LOAD);
    assign smbus_access_en_out = (st_q == rsd_pkg::RSD_ST_SLAVE);
    assign stalled_out         = (st_q == rsd_pkg::RSD_ST_STALL);
    assign slave_addr_out      = addr_q;
    assign slv_rdata_out       = rdata_q;
    assign eq_a_out            = eq_a_q;
    assign eq_b_out            = eq_b_q;
    assign deemph_a_out        = drv_a_q[`RSD_DRV_DEM_LSB +: 3];
    assign deemph_b_out        = drv_b_q[`RSD_DRV_DEM_LSB +: 3];
    assign output_amplitude_a_out = pin_mode_out ? `RSD_AMP_700MV :
                                    drv_a_q[`RSD_DRV_AMP_LSB +: 3];
    assign output_amplitude_b_out = drv_b_q[`RSD_DRV_AMP_LSB +: 3];
    assign sd_thresh_out       = sdth_q;
    assign kr_train_en_out     = pin_mode_out &&
                                 held_q.amp == rsd_pkg::RSD_LVL_1;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    thr_map_a: assert property (pin_mode_out && $past(pin_mode_out) &&
        held_q.idle == rsd_pkg::RSD_LVL_0 |-> sd_thresh_out == 4'ha)
        else $error("Threshold level 0 not decoded to 10");
    load_mode_a: assert property (st_q == rsd_pkg::RSD_ST_SAMPLE &&
        strap_bus.straps.cfg == rsd_pkg::RSD_LVL_F
        |=> load_req_out && bus_master_out)
        else $error("Floating mode strap did not start a load");
    subset_a: assert property (load_req_out && load_wr_in &&
        load_addr_in == `RSD_REG_DRV_A |=> $stable(drv_a_q[1:0]))
        else $error("Load wrote a slave-only bit");
    release_a: assert property (load_req_out && load_done_in &&
        !load_fail_in |=> smbus_access_en_out && !bus_master_out)
        else $error("Good load did not release the bus");
    stall_a: assert property (stalled_out |=>
        stalled_out [*3] ##0 !smbus_access_en_out)
        else $error("Stall was left or gave bus access");
    eq_pin_a: assert property (pin_mode_out && $past(pin_mode_out) &&
        held_q.eqah == rsd_pkg::RSD_LVL_R &&
        held_q.eqal == rsd_pkg::RSD_LVL_R |-> eq_a_out == 8'h15)
        else $error("Equalizer pair R,R not 0x15");
    drv_kr_a: assert property (pin_mode_out && $past(pin_mode_out) &&
        held_q.amp == rsd_pkg::RSD_LVL_1 && held_q.demb == rsd_pkg::RSD_LVL_R
        |-> deemph_b_out == 3'h1 && output_amplitude_b_out == 3'h6)
        else $error("Amplitude strap 1 pair wrong");
    amp_pin_a: assert property (pin_mode_out |->
        output_amplitude_a_out == 3'h0)
        else $error("Side A amplitude not 700 mVpp in pin mode");
    addr_force_a: assert property (smbus_access_en_out &&
        held_q.amp == rsd_pkg::RSD_LVL_1 |-> slave_addr_out == 7'h58)
        else $error("Address straps not forced to zero");
    reg_en_a: assert property (smbus_access_en_out && slv_wr_in &&
        slv_addr_in == `RSD_REG_EQ_A && !ctrl_q[3] |=> $stable(eq_a_out))
        else $error("Setting changed without register enable");
    hold_a: assert property ($past(st_q) != rsd_pkg::RSD_ST_SAMPLE &&
        st_q != rsd_pkg::RSD_ST_SAMPLE |-> $stable(held_q))
        else $error("Strap levels changed after sampling");

    pin_c:   cover property (pin_mode_out && kr_train_en_out);
    slave_c: cover property (load_req_out ##1 smbus_access_en_out);
    stall_c: cover property (load_req_out ##1 stalled_out);
    wr_c:    cover property (set_wr);

endmodule

`default_nettype wire

// [test/rsd_eeprom_model.sv]
/*
 * Behavioural EEPROM master engine: writes a short image, then
 * reports a good or a failed load. Assumes the decoder's clock.
 */
`default_nettype none
module rsd_eeprom_model (
    input  wire logic       mclk_in,  // Clock
    input  wire logic       rst_b_in, // Reset, low
    input  wire logic       req_in,   // Load requested
    input  wire logic       bad_in,   // Report a failed load
    output logic            wr_out,   // Write strobe
    output logic      [7:0] addr_out, // Write offset
    output logic      [7:0] data_out, // Write data
    output logic            done_out, // Load good
    output logic            fail_out  // Load bad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] step_q;
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            {step_q, wr_out, addr_out, data_out} <= '0;
            {done_out, fail_out} <= 2'h0;
        end else begin
            // Idle lines toggle so nothing relies on a stale value
            {wr_out, done_out, fail_out} <= 3'h0;
            addr_out <= ~addr_out;
            data_out <= ~data_out;
            if (req_in && step_q != 2'h3) begin
                step_q <= step_q + 2'h1;
                case (step_q)
                    2'h0: {wr_out, addr_out, data_out} <= 17'h123ff;
                    2'h1: {wr_out, addr_out, data_out} <= 17'h108ff;
                    default: {fail_out, done_out} <= {bad_in, !bad_in};
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// [test/repeater_setting_strap_decode_tb_top.sv]
/*
 * Self-checking bench of the strap decoder: pin decode, slave
 * writes, good and failed EEPROM loads. Assumes rsd_top and model.
 */
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
    miscompares++; $display("BAD %s exp %h got %h", n, e, s); end end
module repeater_setting_strap_decode_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in, rst_b_in, slv_wr_in, bad, load_wr_in, load_done_in;
    logic load_fail_in, load_req_out, bus_master_out, smbus_access_en_out;
    logic stalled_out, pin_mode_out, kr_train_en_out;
    logic [8:0][1:0] st;
    logic [3:0]      slave_addr_straps_in, sd_thresh_out;
    logic [6:0]      slave_addr_out;
    logic [7:0]      slv_addr_in, slv_wdata_in, slv_rd_addr_in;
    logic [7:0]      slv_rdata_out, load_addr_in, load_data_in;
    logic [7:0]      eq_a_out, eq_b_out;
    logic [2:0]      deemph_a_out, deemph_b_out;
    logic [2:0]      output_amplitude_a_out, output_amplitude_b_out;
    logic [2:0] idle_detect_threshold_strap_in, config_mode_strap_in;
    logic [2:0] side_a_eq_strap_hi_in, side_a_eq_strap_lo_in;
    logic [2:0] side_b_eq_strap_hi_in, side_b_eq_strap_lo_in;
    logic [2:0] amplitude_select_strap_in, deemph_strap_a_in;
    logic [2:0] deemph_strap_b_in;
    int miscompares, checks_done, i, k;
    // Levels 0,R,F,1 as a thermometer of 0..3 ones
    function automatic logic [2:0] th(input logic [1:0] l);
        return 3'h7 >> (2'h3 - l);
    endfunction
    assign idle_detect_threshold_strap_in = th(st[0]);
    assign config_mode_strap_in = th(st[1]);
    assign side_a_eq_strap_hi_in = th(st[2]);
    assign side_a_eq_strap_lo_in = th(st[3]);
    assign side_b_eq_strap_hi_in = th(st[4]);
    assign side_b_eq_strap_lo_in = th(st[5]);
    assign amplitude_select_strap_in = th(st[6]);
    assign deemph_strap_a_in = th(st[7]);
    assign deemph_strap_b_in = th(st[8]);
    rsd_top dut (.*);
    rsd_eeprom_model eeprom (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .req_in(load_req_out), .bad_in(bad), .wr_out(load_wr_in),
        .addr_out(load_addr_in), .data_out(load_data_in),
        .done_out(load_done_in), .fail_out(load_fail_in));
    always #2 mclk_in = ~mclk_in;
    task automatic wrap_up();
        if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    `define WAITON(c) for (k = 0; k < 80 && (c) !== 1'b1; k++) \
        begin @(posedge mclk_in); #1; end \
        if (k == 80) begin miscompares++; wrap_up(); end
    // Straps are sampled once, so every setting needs a fresh reset
    task automatic boot(input logic [17:0] s, input logic [3:0] a, int n);
        @(posedge mclk_in);
        {st, slave_addr_straps_in, rst_b_in} <= {s, a, 1'b0};
        repeat (4) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        {slv_wr_in, slv_addr_in, slv_wdata_in} <= {1'b1, a, d};
        @(posedge mclk_in);
        slv_wr_in <= 1'b0;
    endtask
    task automatic pin_scan();
        logic [7:0] eqt [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h15,
            8'h0b, 8'h0f, 8'h55, 8'h1f, 8'h2f, 8'h3f, 8'haa, 8'h7f, 8'hbf,
            8'hff};
        logic [5:0] dat [16] = '{6'h00, 6'h18, 6'h10, 6'h28, 6'h05, 6'h1d,
            6'h15, 6'h2d, 6'h03, 6'h1b, 6'h13, 6'h2b, 6'h04, 6'h0e, 6'h0c,
            6'h16};
        logic [1:0] tt [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
        logic [1:0] h, l;
        for (i = 0; i < 16; i++) begin
            {h, l} = 4'(i);
            boot({l, l, h, l, h, h, l, 2'h0, l}, 4'h0, 32);
            `CHK("pin", 1'b1, pin_mode_out)
            `CHK("eq_a", eqt[{l, h}], eq_a_out)
            `CHK("eq_b", eqt[i], eq_b_out)
            `CHK("drv_b", dat[i], {deemph_b_out, output_amplitude_b_out})
            `CHK("dem_a", dat[i][5:3], deemph_a_out)
            `CHK("amp_a", 3'h0, output_amplitude_a_out)
            `CHK("thr", {tt[l], tt[l]}, sd_thresh_out)
            `CHK("kr", h == 2'h3, kr_train_en_out)
        end
    endtask
    task automatic slave_run();
        boot({2'h0, 2'h0, 2'h1, 8'h0, 2'h3, 2'h0}, 4'hd, 32);
        `CHK("addr", 7'h65, slave_addr_out)
        wr(8'h0f, 8'h5a);
        #1;
        `CHK("locked", 8'h00, eq_a_out)
        wr(8'h06, 8'h08);
        wr(8'h0f, 8'h5a);
        slv_rd_addr_in <= 8'h0f;
        repeat (2) @(posedge mclk_in);
        #1;
        `CHK("eq_w", 8'h5a, eq_a_out)
        `CHK("rd", 8'h5a, slv_rdata_out)
    endtask
    task automatic load_run(input logic b);
        bad = b;
        boot({2'h0, 2'h0, 2'h3, 8'h0, 2'h2, 2'h0}, 4'h5, 0);
        `WAITON(load_req_out)
        `CHK("master", 1'b1, bus_master_out)
        `WAITON(smbus_access_en_out | stalled_out)
        #1;
        `CHK("stall", b, stalled_out)
        `CHK("slave", !b, smbus_access_en_out)
        `CHK("release", 1'b0, bus_master_out)
        `CHK("req_off", 1'b0, load_req_out)
        `CHK("addr0", 7'h58, slave_addr_out)
        `CHK("drv_a", 6'h3f, {deemph_a_out, output_amplitude_a_out})
        `CHK("sdth", 4'h0, sd_thresh_out)
        wr(8'h06, 8'h08);
        wr(8'h0f, 8'h33);
        #1;
        `CHK("eq_a", b ? 8'h00 : 8'h33, eq_a_out)
    endtask
    initial begin
        {mclk_in, rst_b_in, slv_wr_in, bad, st} = '0;
        {slave_addr_straps_in, slv_addr_in, slv_wdata_in} = '0;
        slv_rd_addr_in = 8'h00;
        pin_scan();
        slave_run();
        load_run(1'b0);
        load_run(1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
